// file: pkg/acsp_pkg.sv
// package: register map, field positions and timing constants of the configuration serial port
package acsp_pkg;
	localparam int          FRAME_BITS      = 16;
	localparam int          ADDR_BITS       = 8;
	localparam int          DATA_BITS       = 8;
	localparam int          CNT_W           = 4;
	localparam int          CLK_PERIOD_NS   = 4;
	localparam int          SCLK_MAX_MHZ    = 20;
	localparam int          HW_RESET_MIN_NS = 10;
	localparam int          HW_RESET_CYC    = (HW_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int          SCLK_MIN_HALF_NS = 1000 / (2 * SCLK_MAX_MHZ);
	localparam int          SCLK_HALF_CYC   = (SCLK_MIN_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          SCLK_DIV_W      = 8;
	localparam logic [3:0]  LAST_BIT        = 4'hF;
	localparam logic [7:0]  ADDR_CTRL       = 8'h00;
	localparam logic [7:0]  ADDR_SWING      = 8'h01;
	localparam logic [7:0]  ADDR_SWING_EN   = 8'hF1;
	localparam logic [7:0]  REG_RESET_VAL   = 8'h00;
	localparam int          CTRL_READBACK_BIT = 0;
	localparam int          CTRL_SWRESET_BIT  = 1;
	localparam int          SWING_LSB       = 2;
	localparam logic [1:0]  SWING_EN_ON     = 2'h3;
	localparam logic [5:0]  SWING_DEFAULT   = 6'h00;
	// host command port offsets
	localparam logic [1:0]  HOST_CMD_ADDR   = 2'h0;
	localparam logic [1:0]  HOST_STAT_ADDR  = 2'h1;
	localparam logic [1:0]  HOST_RDATA_ADDR = 2'h2;
	localparam logic [1:0]  HOST_DIV_ADDR   = 2'h3;
	localparam int          CMD_RESET_BIT   = 16;
	localparam int          CMD_READ_BIT    = 17;
	localparam int          STAT_BUSY_BIT   = 0;
	localparam logic [7:0]  HOST_DIV_DEFAULT = 8'h03;
	localparam logic [31:0] BUS_ZERO        = 32'h0000_0000;
	// mapped register offsets
	localparam int          NUM_REGS = 32;
	localparam logic [7:0]  REG_ADDRS [NUM_REGS] = '{
		8'h01, 8'h25, 8'h2B, 8'h31, 8'h37, 8'h3D, 8'h3F, 8'h40,
		8'h41, 8'h42, 8'h44, 8'h45, 8'h4A, 8'h62, 8'h7A, 8'h92,
		8'hA9, 8'hAC, 8'hC3, 8'hC4, 8'hCF, 8'hD4, 8'hD5, 8'hD6,
		8'hD7, 8'hDB, 8'hEA, 8'hF0, 8'hF1, 8'hF5, 8'hFE, 8'h01};
	typedef enum logic [1:0] {
		ACSP_IDLE  = 2'b00,
		ACSP_SHIFT = 2'b01,
		ACSP_PULSE = 2'b10,
		ACSP_DONE  = 2'b11
	} acsp_host_state_t;
endpackage

// file: pkg/acsp_if.sv
// interface: the serial configuration link between host and converter
interface acsp_if;
	logic serial_select_n;
	logic serial_clk;
	logic serial_in_pin;
	logic serial_out_pin_o;
	logic serial_out_pin_oe;
	logic hw_reset;
	logic serial_out_pin;
	assign serial_out_pin = serial_out_pin_oe ? serial_out_pin_o : 1'b1;
	modport device (
		input  serial_select_n,
		input  serial_clk,
		input  serial_in_pin,
		input  hw_reset,
		output serial_out_pin_o,
		output serial_out_pin_oe
	);
	modport host (
		output serial_select_n,
		output serial_clk,
		output serial_in_pin,
		output hw_reset,
		input  serial_out_pin
	);
endinterface

// file: hw/acsp_device.sv
// device end: frame capture, register map, read-back and resets
//
// Operation
// - shift only while select is low
// - sample input on serial clock falling edge
// - every sixteenth falling edge commits the frame
// - partial frame discarded when select rises
// - many frames allowed under one select
// - first eight bits address, next eight data
// - host keeps serial clock at most 20 MHz
// - hardware reset pulse restores register defaults
// - software reset bit restores defaults, self-clears
// - host initialises registers after power-up
// - read-back mode blocks writes except address zero
// - read-back frame shifts addressed register out
// - output bit changes after serial clock rise
// - host captures output on falling edge
// - clearing read-back bit re-enables writes
// - address zero not readable by read-back
// - output tri-stated while read-back disabled
// - read-back enable is bit zero of address zero
// - swing field applies only when enable is 11
//
// The implementer's own choice: the strobed register port.
module acsp_device
	import acsp_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        reset_i,
	acsp_if.device           link,
	output logic [5:0]       swing_level_o,
	output logic [7:0]       reg_image_o [NUM_REGS],
	output logic             readback_en_o
);
	logic [2:0]           sel_sync_reg;
	logic [2:0]           clk_sync_reg;
	logic [1:0]           din_sync_reg;
	logic [2:0]           hwr_sync_reg;
	logic                 sel_active;
	logic                 sclk_fall;
	logic                 sclk_rise;
	logic [CNT_W-1:0]     bit_cnt_reg;
	logic [FRAME_BITS-2:0] shift_reg;
	logic [FRAME_BITS-1:0] frame;
	logic                 commit;
	logic                 hw_reset;
	logic                 sw_reset;
	logic                 readback_reg;
	logic [7:0]           regs_reg [NUM_REGS];
	logic [7:0]           read_value;
	logic [DATA_BITS-1:0] out_shift_reg;
	logic                 out_bit_reg;
	logic                 rd_armed_reg;
	logic [7:0]           addr_early;
	logic [NUM_REGS-1:0]  wr_hit;
	logic [NUM_REGS-1:0]  rd_hit;
	logic                 wr_ok;
	logic                 rd_load;
	logic                 rd_step;
	logic [5:0]           swing_field;
	logic [1:0]           swing_program_enable_field;

	// slot positions of the swing level and its enable inside REG_ADDRS
	localparam logic [CNT_W-1:0] HALF_CNT      = CNT_W'(ADDR_BITS);
	localparam int               SWING_SLOT    = 0;
	localparam int               SWING_EN_SLOT = 28;

	//////////////////////////////////////////////////////////////////////////
	// pin synchronisers: first stage feeds only the second
	always_ff @(posedge mclk_i) begin
		sel_sync_reg <= {sel_sync_reg[1:0], link.serial_select_n};
		clk_sync_reg <= {clk_sync_reg[1:0], link.serial_clk};
		din_sync_reg <= {din_sync_reg[0], link.serial_in_pin};
		hwr_sync_reg <= {hwr_sync_reg[1:0], link.hw_reset};
	end

	assign sel_active = ~sel_sync_reg[1];
	assign sclk_fall  = clk_sync_reg[2] & ~clk_sync_reg[1] & sel_active;
	assign sclk_rise  = ~clk_sync_reg[2] & clk_sync_reg[1] & sel_active;
	// pulse wider than 10 ns spans at least two samples at 4 ns
	assign hw_reset   = hwr_sync_reg[1] & hwr_sync_reg[2];
	assign frame      = {shift_reg, din_sync_reg[1]};
	assign commit     = sclk_fall && bit_cnt_reg == LAST_BIT;
	assign sw_reset   = commit && frame[15:8] == ADDR_CTRL && frame[CTRL_SWRESET_BIT];

	//////////////////////////////////////////////////////////////////////////
	// bit counter: a rising select throws away any partial frame
	always_ff @(posedge mclk_i) begin
		if (reset_i || !sel_active) begin
			bit_cnt_reg <= '0;
		end else if (sclk_fall) begin
			bit_cnt_reg <= bit_cnt_reg + 4'h1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			shift_reg <= '0;
		end else if (sclk_fall) begin
			shift_reg <= frame[FRAME_BITS-2:0];
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// control register; the reset bit never stores, so it reads as self-cleared
	always_ff @(posedge mclk_i) begin
		if (reset_i || hw_reset || sw_reset) begin
			readback_reg <= 1'b0;
		end else if (commit && frame[15:8] == ADDR_CTRL) begin
			readback_reg <= frame[CTRL_READBACK_BIT];
		end
	end

	// one entry per mapped offset; last slot aliases 01h and stays unused
	genvar gi;
	generate
		for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
			always_ff @(posedge mclk_i) begin
				if (reset_i || hw_reset || sw_reset) begin
					regs_reg[gi] <= REG_RESET_VAL;
				end else if (commit && wr_ok && wr_hit[gi]) begin
					regs_reg[gi] <= frame[DATA_BITS-1:0];
				end
			end
			assign reg_image_o[gi] = regs_reg[gi];
		end
	endgenerate

	// lockout keeps register contents fixed while software reads them back
	assign wr_ok = !readback_reg;

	// one-hot decode shared by write and read-back; the alias slot never matches
	generate
		for (gi = 0; gi < NUM_REGS; gi++) begin : g_hit
			assign wr_hit[gi] = (frame[FRAME_BITS-1:DATA_BITS] == REG_ADDRS[gi]) && (gi < NUM_REGS - 1);
			assign rd_hit[gi] = (addr_early == REG_ADDRS[gi]) && (gi < NUM_REGS - 1);
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////
	// read-back: address known after eighth fall, data shifted on rises
	assign addr_early = shift_reg[ADDR_BITS-1:0];
	assign rd_load    = sclk_rise && bit_cnt_reg == HALF_CNT && readback_reg;
	assign rd_step    = sclk_rise && rd_armed_reg;

	// unmapped offsets and the control byte read back as zero
	always_comb begin
		read_value = '0;
		for (int i = 0; i < NUM_REGS; i++) begin
			if (rd_hit[i]) begin
				read_value = regs_reg[i];
			end
		end
	end

	// armed from the first data rise until the rise after the frame wraps
	always_ff @(posedge mclk_i) begin
		if (reset_i || !sel_active) begin
			rd_armed_reg <= 1'b0;
		end else if (rd_load) begin
			rd_armed_reg <= 1'b1;
		end else if (rd_step) begin
			rd_armed_reg <= bit_cnt_reg != '0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i || !sel_active) begin
			out_shift_reg <= '0;
		end else if (rd_load) begin
			out_shift_reg <= {read_value[DATA_BITS-2:0], 1'b0};
		end else if (rd_step) begin
			out_shift_reg <= {out_shift_reg[DATA_BITS-2:0], 1'b0};
		end
	end

	// output moves only on a rise or when a rising select clears it, so the host has a full low phase to sample
	always_ff @(posedge mclk_i) begin
		if (reset_i || !sel_active) begin
			out_bit_reg <= 1'b0;
		end else if (rd_load) begin
			out_bit_reg <= read_value[DATA_BITS-1];
		end else if (rd_step) begin
			out_bit_reg <= out_shift_reg[DATA_BITS-1];
		end
	end

	assign link.serial_out_pin_o  = out_bit_reg;
	assign link.serial_out_pin_oe = readback_reg;
	assign readback_en_o          = readback_reg;
	assign swing_field                = regs_reg[SWING_SLOT][7:SWING_LSB];
	assign swing_program_enable_field = regs_reg[SWING_EN_SLOT][1:0];
	// a half-set enable must not leak a partly programmed swing
	assign swing_level_o = (swing_program_enable_field == SWING_EN_ON)
		? swing_field : SWING_DEFAULT;
endmodule

// file: hw/acsp_host.sv
// host end: drives frames, reset pulse and read-back capture from a command port
module acsp_host
	import acsp_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        reset_i,
	acsp_if.host             link,
	input  wire logic [1:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic [31:0]      rdata_o
);
	acsp_host_state_t     state_reg;
	logic [15:0]          frame_reg;
	logic [3:0]           bit_reg;
	logic [SCLK_DIV_W-1:0] div_reg;
	logic [SCLK_DIV_W-1:0] div_cfg_reg;
	logic                 sclk_reg;
	logic [7:0]           rx_reg;
	logic [7:0]           rdata_hold_reg;
	logic [1:0]           dout_sync_reg;
	logic                 is_reset_reg;
	logic [31:0]          rdata_reg;
	logic                 tick;

	assign tick = div_reg == '0;

	always_ff @(posedge mclk_i) begin
		dout_sync_reg <= {dout_sync_reg[0], link.serial_out_pin};
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			// default sits on the floor so the first frame already meets 20 MHz
			div_cfg_reg <= SCLK_DIV_W'(SCLK_HALF_CYC);
		end else if (wr_i && addr_i == HOST_DIV_ADDR) begin
			// floor keeps the serial clock at or below 20 MHz
			div_cfg_reg <= (wdata_i[SCLK_DIV_W-1:0] < SCLK_DIV_W'(SCLK_HALF_CYC))
				? SCLK_DIV_W'(SCLK_HALF_CYC) : wdata_i[SCLK_DIV_W-1:0];
		end
	end

	//////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			state_reg    <= ACSP_IDLE;
			frame_reg    <= '0;
			bit_reg      <= '0;
			div_reg      <= '0;
			sclk_reg     <= 1'b0;
			rx_reg       <= '0;
			is_reset_reg <= 1'b0;
		end else begin
			case (state_reg)
				ACSP_IDLE: begin
					// reset pulse length is fixed, not tied to the clock divider
					div_reg <= (wr_i && addr_i == HOST_CMD_ADDR && wdata_i[CMD_RESET_BIT])
						? SCLK_DIV_W'(HW_RESET_CYC) : div_cfg_reg;
					if (wr_i && addr_i == HOST_CMD_ADDR) begin
						frame_reg    <= wdata_i[15:0];
						bit_reg      <= '0;
						sclk_reg     <= 1'b1;
						is_reset_reg <= wdata_i[CMD_RESET_BIT];
						state_reg    <= wdata_i[CMD_RESET_BIT] ? ACSP_PULSE : ACSP_SHIFT;
					end
				end
				ACSP_SHIFT: begin
					div_reg <= tick ? div_cfg_reg : div_reg - 1'b1;
					if (tick) begin
						sclk_reg <= ~sclk_reg;
						if (sclk_reg) begin
							rx_reg <= {rx_reg[6:0], dout_sync_reg[1]};
						end else begin
							frame_reg <= {frame_reg[14:0], 1'b0};
							bit_reg   <= bit_reg + 4'h1;
							if (bit_reg == LAST_BIT) begin
								state_reg <= ACSP_DONE;
							end
						end
					end
				end
				ACSP_PULSE: begin
					div_reg <= div_reg - 1'b1;
					if (div_reg == '0) begin
						state_reg <= ACSP_DONE;
					end
				end
				ACSP_DONE: begin
					sclk_reg     <= 1'b1;
					is_reset_reg <= 1'b0;
					state_reg    <= ACSP_IDLE;
				end
				default: state_reg <= ACSP_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			rdata_hold_reg <= '0;
		end else if (state_reg == ACSP_DONE) begin
			rdata_hold_reg <= rx_reg;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			rdata_reg <= BUS_ZERO;
		end else if (rd_i) begin
			case (addr_i)
				HOST_STAT_ADDR:  rdata_reg <= {31'h0, state_reg != ACSP_IDLE};
				HOST_RDATA_ADDR: rdata_reg <= {24'h0, rdata_hold_reg};
				HOST_DIV_ADDR:   rdata_reg <= {24'h0, div_cfg_reg};
				default:         rdata_reg <= BUS_ZERO;
			endcase
		end else begin
			rdata_reg <= BUS_ZERO;
		end
	end

	assign rdata_o              = rdata_reg;
	assign link.serial_select_n = state_reg != ACSP_SHIFT;
	assign link.serial_clk      = sclk_reg | (state_reg != ACSP_SHIFT);
	assign link.serial_in_pin   = frame_reg[15];
	assign link.hw_reset        = state_reg == ACSP_PULSE && is_reset_reg;
endmodule

// file: verification/acsp_chk.sv
// checker: framing, timing and drive properties of the serial configuration link
module acsp_chk (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic serial_select_n,
	input wire logic serial_clk,
	input wire logic serial_in_pin,
	input wire logic serial_out_pin_o,
	input wire logic serial_out_pin_oe,
	input wire logic hw_reset,
	input wire logic readback_en_o
);
	logic       sclk_q;
	logic [3:0] fall_cnt;
	logic [4:0] per_cnt;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk_i)
		sclk_q <= serial_clk;
	// a partial frame leaves a nonzero remainder when select rises
	always_ff @(posedge mclk_i)
		if (reset_i || serial_select_n)
			fall_cnt <= 4'h0;
		else if (sclk_q && !serial_clk)
			fall_cnt <= fall_cnt + 4'h1;
	// saturates so that a slow clock never wraps into a false short period
	always_ff @(posedge mclk_i)
		if (reset_i)
			per_cnt <= 5'h1F;
		else if (!sclk_q && serial_clk)
			per_cnt <= 5'h00;
		else if (per_cnt != 5'h1F)
			per_cnt <= per_cnt + 5'h01;
	////////////////////////////////////////////////////////////////
	AST_SCLK_RATE: assert property ($rose(serial_clk) && !serial_select_n |-> per_cnt >= 5'h0C)
		else $error("serial clock period too short");
	AST_IDLE_CLK: assert property (serial_select_n[*3] |-> serial_clk)
		else $error("serial clock moves while deselected");
	AST_WHOLE_FRAMES: assert property ($rose(serial_select_n) |-> fall_cnt == 4'h0)
		else $error("select rose inside a frame");
	AST_DATA_HOLD: assert property (!serial_select_n && sclk_q && !serial_clk |->
		$stable(serial_in_pin) ##1 $stable(serial_in_pin))
		else $error("input data moved at the sampling edge");
	AST_RESET_WIDTH: assert property ($rose(hw_reset) |-> hw_reset[*3])
		else $error("reset pulse too short");
	AST_RESET_CLEARS: assert property (hw_reset[*3] |-> ##[1:6] !readback_en_o)
		else $error("reset left read-back enabled");
	AST_TRISTATE: assert property ((!readback_en_o)[*8] |-> !serial_out_pin_oe)
		else $error("output driven with read-back off");
	AST_OUT_AFTER_RISE: assert property ((!serial_clk)[*6] ##0 serial_out_pin_oe && $past(serial_out_pin_oe)
		|-> $stable(serial_out_pin_o))
		else $error("output changed in the low phase");
	COV_READBACK: cover property ($rose(serial_out_pin_oe));
	COV_HW_RESET: cover property ($rose(hw_reset));
	COV_FRAME_END: cover property ($rose(serial_select_n) && fall_cnt == 4'h0);
endmodule

// file: verification/adc_config_serial_port_tb.sv
// testbench: host and device ends over one link, plus a bit-banged second device
module adc_config_serial_port_tb;
	import acsp_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
	logic        mclk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic [1:0]  addr_i = 2'h0;
	logic [31:0] wdata_i = 32'h0000_0000;
	logic [31:0] rdata_o;
	logic [31:0] d;
	logic [7:0]  img [NUM_REGS];
	logic [7:0]  img2 [NUM_REGS];
	logic [7:0]  ra [3] = '{8'h25, 8'hFE, 8'h00};
	logic [5:0]  swing;
	logic        rb_en;
	logic        sclk_q;
	logic [15:0] mon;
	int          err_count = 0;
	int          total_checks = 0;
	acsp_if lk();
	acsp_if lk2();
	always #2 mclk_i = ~mclk_i;
	acsp_host acsp_host_inst (.mclk_i(mclk_i), .reset_i(reset_i), .link(lk), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
	acsp_device acsp_device_inst (.mclk_i(mclk_i), .reset_i(reset_i), .link(lk), .swing_level_o(swing),
		.reg_image_o(img), .readback_en_o(rb_en));
	acsp_device acsp_device_bb_inst (.mclk_i(mclk_i), .reset_i(reset_i), .link(lk2), .swing_level_o(),
		.reg_image_o(img2), .readback_en_o());
	acsp_chk acsp_chk_inst (.mclk_i(mclk_i), .reset_i(reset_i), .serial_select_n(lk.serial_select_n),
		.serial_clk(lk.serial_clk), .serial_in_pin(lk.serial_in_pin), .serial_out_pin_o(lk.serial_out_pin_o),
		.serial_out_pin_oe(lk.serial_out_pin_oe), .hw_reset(lk.hw_reset), .readback_en_o(rb_en));
	////////////////////////////////////////////////////////////////
	// wire monitor: bits as the device would see them
	always @(posedge mclk_i) begin
		sclk_q <= lk.serial_clk;
		if (!lk.serial_select_n && sclk_q && !lk.serial_clk)
			mon <= {mon[14:0], lk.serial_in_pin};
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [1:0] a, input logic [31:0] v);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask
	// commands are refused while busy, so every one waits for idle
	task automatic cmd(input logic [31:0] v);
		int n;
		wr(HOST_CMD_ADDR, v);
		d = 32'h0000_0001;
		for (n = 0; n < 500 && d[STAT_BUSY_BIT] !== 1'b0; n++)
			rd(HOST_STAT_ADDR);
		`CHK("busy", 1'b0, d[STAT_BUSY_BIT])
		repeat (6) @(posedge mclk_i);
	endtask
	// 64 ns serial clock, data set at the start of each high phase
	task automatic bb(input logic [39:0] b, input int n, input logic sel);
		@(posedge mclk_i);
		lk2.serial_select_n <= !sel;
		for (int i = n - 1; i >= 0; i--) begin
			lk2.serial_in_pin <= b[i];
			repeat (8) @(posedge mclk_i);
			lk2.serial_clk <= 1'b0;
			repeat (8) @(posedge mclk_i);
			lk2.serial_clk <= 1'b1;
		end
		repeat (8) @(posedge mclk_i);
		lk2.serial_select_n <= 1'b1;
		lk2.serial_in_pin <= ~lk2.serial_in_pin;
		repeat (8) @(posedge mclk_i);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (40000) @(posedge mclk_i);
		err_count++;
		end_of_test();
	end
	initial begin
		lk2.serial_select_n = 1'b1;
		lk2.serial_clk = 1'b1;
		lk2.serial_in_pin = 1'b0;
		lk2.hw_reset = 1'b0;
		repeat (20) @(posedge mclk_i);
		reset_i <= 1'b0;
		@(posedge mclk_i);
		for (int i = 0; i < NUM_REGS - 1; i++) `CHK("reset image", REG_RESET_VAL, img[i])
		`CHK("idle out", 1'b1, lk.serial_out_pin)
		rd(HOST_DIV_ADDR);
		`CHK("div default", SCLK_HALF_CYC, d[7:0])
		wr(HOST_DIV_ADDR, 32'h0000_0006);
		rd(HOST_DIV_ADDR);
		`CHK("div floor", SCLK_HALF_CYC, d[7:0])
		cmd(32'h0001_0000);
		$display("test reset done");
		for (int i = 0; i < NUM_REGS - 1; i++) begin
			cmd({16'h0000, REG_ADDRS[i], REG_ADDRS[i] ^ 8'hA5});
			`CHK("wire frame", {REG_ADDRS[i], REG_ADDRS[i] ^ 8'hA5}, mon)
			`CHK("reg write", REG_ADDRS[i] ^ 8'hA5, img[i])
		end
		`CHK("swing off", SWING_DEFAULT, swing)
		cmd({16'h0000, ADDR_SWING_EN, 6'h00, SWING_EN_ON});
		`CHK("swing on", 6'((ADDR_SWING ^ 8'hA5) >> SWING_LSB), swing)
		$display("test writes done");
		cmd({16'h0000, ADDR_CTRL, 8'h01});
		`CHK("rb on", 1'b1, rb_en)
		cmd({16'h0000, 8'h25, 8'h5A});
		`CHK("locked", 8'h25 ^ 8'hA5, img[1])
		for (int j = 0; j < 3; j++) begin
			cmd({16'h0000, ra[j], (ra[j] == ADDR_CTRL) ? 8'h01 : 8'h00});
			rd(HOST_RDATA_ADDR);
			`CHK("readback", (ra[j] == ADDR_CTRL) ? 8'h00 : ra[j] ^ 8'hA5, d[7:0])
		end
		cmd({16'h0000, ADDR_CTRL, 8'h00});
		`CHK("rb off", 1'b0, rb_en)
		`CHK("out released", 1'b0, lk.serial_out_pin_oe)
		cmd({16'h0000, 8'h25, 8'h5A});
		`CHK("unlocked", 8'h5A, img[1])
		$display("test readback done");
		cmd({16'h0000, ADDR_CTRL, 8'h02});
		`CHK("sw reset a", REG_RESET_VAL, img[1])
		`CHK("sw reset b", REG_RESET_VAL, img[30])
		cmd({16'h0000, 8'h2B, 8'h66});
		`CHK("after self clear", 8'h66, img[2])
		cmd({16'h0000, ADDR_CTRL, 8'h01});
		`CHK("rb on again", 1'b1, rb_en)
		cmd(32'h0001_0000);
		`CHK("hw reset", REG_RESET_VAL, img[2])
		`CHK("hw reset rb", 1'b0, rb_en)
		$display("test resets done");
		bb(40'h00_0000_0000, 4, 1'b0);
		bb(40'h00_0000_0ABC, 12, 1'b1);
		bb({3'h0, 8'h25, 8'h11, 8'h2B, 8'h22, 5'h15}, 37, 1'b1);
		`CHK("burst first", 8'h11, img2[1])
		`CHK("burst second", 8'h22, img2[2])
		$display("test framing done");
		end_of_test();
	end
endmodule
